// File: src/aod_output_regs.sv
`timescale 1ns/1ps
module aod_output_regs (
    input wire logic ref_clk,
    input wire logic rst,
    input wire aod_pkg::aod_spi_in_type spi_in,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic sample_start,
    output logic conv_req,
    output aod_pkg::aod_chan_type conv_chan,
    input wire logic [11:0] conv_data,
    input wire logic conv_valid,
    output logic data_ready
);
    import aod_pkg::*;

    typedef enum logic [2:0] {
        SQ_IDLE,
        SQ_REQ,
        SQ_WAIT,
        SQ_GAP,
        SQ_SQRT,
        SQ_LATCH
    } aod_seq_type;

    aod_seq_type seq_r;
    aod_chan_type chan_r;
    logic [10:0] gap_r;
    logic [3:0] bit_idx_r;
    logic [11:0] root_r;
    aod_sample_type shadow_r;
    aod_sample_type out_r;
    logic [11:0] vector_magnitude_value_r;
    logic [7:0] cfg2_r;
    logic [7:0] cfg5_r;
    logic drdy_r;

    logic [2:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic sclk_rise;
    logic sclk_fall;
    logic selected;
    logic [2:0] bitcnt_r;
    logic [7:0] rx_r;
    logic [7:0] tx_r;
    logic [6:0] addr_r;
    logic addr_phase_r;
    logic read_r;
    logic [7:0] rx_byte;
    logic byte_done;
    logic [6:0] load_addr;
    logic [7:0] rd_data;
    logic rd_load;
    logic rd_clear;
    logic wr_strobe;

    logic big_end;
    logic fast_rd;
    logic mag_en;
    logic [25:0] sq_sum;
    logic [25:0] ext_x;
    logic [25:0] ext_y;
    logic [25:0] ext_z;
    logic [11:0] cand;
    logic [23:0] cand_sq;
    logic [11:0] sel_axis;

    assign big_end = cfg2_r[BYTE_ORDER_BIT];
    assign fast_rd = cfg2_r[FAST_READ_BIT];
    assign mag_en = cfg5_r[MAG_EN_BIT];
    assign data_ready = drdy_r;
    assign conv_chan = chan_r;
    assign conv_req = (seq_r == SQ_REQ);

    // Sum of squares from the shadow set, which is stable in SQRT; axes are
    // sign-extended first so no product is cut to the operand width
    always_comb begin
        ext_x = {{14{shadow_r.x[11]}}, shadow_r.x};
        ext_y = {{14{shadow_r.y[11]}}, shadow_r.y};
        ext_z = {{14{shadow_r.z[11]}}, shadow_r.z};
        sq_sum = ext_x * ext_x + ext_y * ext_y + ext_z * ext_z;
        cand = root_r | (12'h001 << bit_idx_r);
        cand_sq = cand * cand;
    end

    // Acquisition sequencer: one conversion per channel, gap between them
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            seq_r <= SQ_IDLE;
            chan_r <= AOD_CH_TEMP;
            gap_r <= 11'h000;
            bit_idx_r <= 4'h0;
        end else begin
            case (seq_r)
                SQ_IDLE: begin
                    if (sample_start) begin
                        chan_r <= AOD_CH_TEMP;
                        seq_r <= SQ_REQ;
                    end
                end
                SQ_REQ: seq_r <= SQ_WAIT;
                SQ_WAIT: begin
                    if (conv_valid) begin
                        if (chan_r != AOD_CH_Z) begin
                            gap_r <= ACQ_GAP_LAST;
                            seq_r <= SQ_GAP;
                        end else if (mag_en) begin
                            bit_idx_r <= 4'hB;
                            seq_r <= SQ_SQRT;
                        end else begin
                            seq_r <= SQ_LATCH;
                        end
                    end
                end
                SQ_GAP: begin
                    if (gap_r == 11'h000) begin
                        chan_r <= aod_chan_type'(chan_r + 2'h1);
                        seq_r <= SQ_REQ;
                    end else begin
                        gap_r <= gap_r - 11'h001;
                    end
                end
                SQ_SQRT: begin
                    if (bit_idx_r == 4'h0) begin
                        seq_r <= SQ_LATCH;
                    end else begin
                        bit_idx_r <= bit_idx_r - 4'h1;
                    end
                end
                SQ_LATCH: seq_r <= SQ_IDLE;
                default: seq_r <= SQ_IDLE;
            endcase
        end
    end

    // Shadow capture of each conversion result as it arrives
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shadow_r <= '0;
        end else if (seq_r == SQ_WAIT && conv_valid) begin
            case (chan_r)
                AOD_CH_TEMP: shadow_r.temp <= conv_data[7:0];
                AOD_CH_X: shadow_r.x <= conv_data;
                AOD_CH_Y: shadow_r.y <= conv_data;
                AOD_CH_Z: shadow_r.z <= conv_data;
                default: shadow_r.z <= conv_data;
            endcase
        end
    end

    // Bit-serial square root, one result bit per cycle from the top
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            root_r <= 12'h000;
        end else if (seq_r == SQ_WAIT) begin
            root_r <= 12'h000;
        end else if (seq_r == SQ_SQRT && {2'b00, cand_sq} <= sq_sum) begin
            root_r <= cand;
        end
    end

    // Output set and magnitude load in one edge, so a read never mixes sets
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_r <= '0;
            vector_magnitude_value_r <= VECTOR_MAGNITUDE_VALUE_RST;
        end else if (seq_r == SQ_LATCH) begin
            out_r <= shadow_r;
            if (mag_en) begin
                vector_magnitude_value_r <= root_r;
            end
        end
    end

    // Data-ready flag: a new set wins over a clearing read in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            drdy_r <= 1'b0;
        end else if (seq_r == SQ_LATCH) begin
            drdy_r <= 1'b1;
        end else if (rd_clear) begin
            drdy_r <= 1'b0;
        end
    end

    // Serial pins cross into ref_clk through two flip-flops each
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_s <= 3'h0;
            cs_s <= 2'h3;
            mosi_s <= 2'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], spi_in.sclk};
            cs_s <= {cs_s[0], spi_in.cs_n};
            mosi_s <= {mosi_s[0], spi_in.mosi};
        end
    end

    assign selected = !cs_s[1];
    assign sclk_rise = selected && sclk_s[1] && !sclk_s[2];
    assign sclk_fall = selected && !sclk_s[1] && sclk_s[2];
    assign rx_byte = {rx_r[6:0], mosi_s[1]};
    assign byte_done = sclk_rise && (bitcnt_r == 3'h7);

    // Next burst address; fast read hops over every upper byte
    function automatic logic [6:0] next_addr(input logic [6:0] a,
                                             input logic fast);
        if (fast && a >= VECTOR_MAGNITUDE_VALUE_LO_ADDR && a <= Z_LO_ADDR && !a[0]) begin
            next_addr = a + 7'h02;
        end else begin
            next_addr = a + 7'h01;
        end
    endfunction

    // Lower byte of a 12-bit value in the current byte order
    function automatic logic [7:0] low_byte(input logic [11:0] v,
                                            input logic msb_first);
        low_byte = msb_first ? v[11:4] : v[7:0];
    endfunction

    // Upper byte: sign-filled or zero-filled nibble, or left-justified
    function automatic logic [7:0] high_byte(input logic [11:0] v,
                                             input logic msb_first,
                                             input logic signed_val);
        if (msb_first) begin
            high_byte = {v[3:0], 4'h0};
        end else if (signed_val) begin
            high_byte = {{4{v[11]}}, v[11:8]};
        end else begin
            high_byte = {4'h0, v[11:8]};
        end
    endfunction

    // Address of the byte to load when the current byte completes
    assign load_addr = addr_phase_r ? rx_byte[6:0]
                                    : next_addr(addr_r, fast_rd);
    assign rd_load = byte_done && (addr_phase_r ? rx_byte[CMD_READ_BIT]
                                                : read_r);
    assign wr_strobe = byte_done && !addr_phase_r && !read_r;
    assign rd_clear = rd_load && load_addr >= VECTOR_MAGNITUDE_VALUE_LO_ADDR
                      && load_addr <= Z_HI_ADDR;

    // Read data mux over the mapped offsets; unmapped offsets read zero
    always_comb begin
        sel_axis = out_r.x;
        rd_data = 8'h00;
        case (load_addr)
            Y_LO_ADDR, Y_HI_ADDR: sel_axis = out_r.y;
            Z_LO_ADDR, Z_HI_ADDR: sel_axis = out_r.z;
            default: sel_axis = out_r.x;
        endcase
        case (load_addr)
            STATUS_ADDR: rd_data = {drdy_r, 7'h00};
            TEMP_ADDR: rd_data = out_r.temp;
            VECTOR_MAGNITUDE_VALUE_LO_ADDR: rd_data = low_byte(vector_magnitude_value_r, big_end);
            VECTOR_MAGNITUDE_VALUE_HI_ADDR: rd_data = high_byte(vector_magnitude_value_r, big_end, 1'b0);
            X_LO_ADDR, Y_LO_ADDR, Z_LO_ADDR:
                rd_data = low_byte(sel_axis, big_end || fast_rd);
            X_HI_ADDR, Y_HI_ADDR, Z_HI_ADDR:
                rd_data = high_byte(sel_axis, big_end || fast_rd, 1'b1);
            CFG2_ADDR: rd_data = cfg2_r;
            CFG5_ADDR: rd_data = cfg5_r;
            default: rd_data = 8'h00;
        endcase
    end

    // Serial shifter: sample on rising sclk, present on falling sclk
    always_ff @(posedge ref_clk) begin
        if (rst || !selected) begin
            bitcnt_r <= 3'h0;
            rx_r <= 8'h00;
            tx_r <= 8'h00;
            addr_r <= 7'h00;
            addr_phase_r <= 1'b1;
            read_r <= 1'b0;
        end else begin
            if (sclk_rise) begin
                rx_r <= rx_byte;
                bitcnt_r <= bitcnt_r + 3'h1;
            end else if (sclk_fall && bitcnt_r != 3'h0) begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
            if (byte_done) begin
                addr_phase_r <= 1'b0;
                if (addr_phase_r) begin
                    read_r <= rx_byte[CMD_READ_BIT];
                end
                addr_r <= load_addr;
                if (rd_load) begin
                    tx_r <= rd_data;
                end
            end
        end
    end

    // Configuration writes; a burst write advances as a read does, two bytes at a time where fast read hops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg2_r <= CFG2_RST;
            cfg5_r <= CFG5_RST;
        end else if (wr_strobe) begin
            if (addr_r == CFG2_ADDR) begin
                cfg2_r <= rx_byte;
            end
            if (addr_r == CFG5_ADDR) begin
                cfg5_r <= rx_byte;
            end
        end
    end

    // Data pin comes straight from the shift register flop
    assign spi_miso = tx_r[7];
    assign spi_miso_oe = selected && read_r && !addr_phase_r;
endmodule

// File: include/aod_pkg.sv
package aod_pkg;
    // Timing of the acquisition sequence
    localparam int CLK_FREQ_MHZ = 40;
    localparam int ACQ_GAP_US = 40;
    localparam int ACQ_GAP_CYC = ACQ_GAP_US * CLK_FREQ_MHZ;
    localparam logic [10:0] ACQ_GAP_LAST = 11'(ACQ_GAP_CYC - 1);

    // Register offsets
    localparam logic [6:0] STATUS_ADDR = 7'h00;
    localparam logic [6:0] TEMP_ADDR = 7'h01;
    localparam logic [6:0] VECTOR_MAGNITUDE_VALUE_LO_ADDR = 7'h02;
    localparam logic [6:0] VECTOR_MAGNITUDE_VALUE_HI_ADDR = 7'h03;
    localparam logic [6:0] X_LO_ADDR = 7'h04;
    localparam logic [6:0] X_HI_ADDR = 7'h05;
    localparam logic [6:0] Y_LO_ADDR = 7'h06;
    localparam logic [6:0] Y_HI_ADDR = 7'h07;
    localparam logic [6:0] Z_LO_ADDR = 7'h08;
    localparam logic [6:0] Z_HI_ADDR = 7'h09;
    localparam logic [6:0] CFG2_ADDR = 7'h15;
    localparam logic [6:0] CFG5_ADDR = 7'h18;

    // Field positions
    localparam int CMD_READ_BIT = 7;
    localparam int DRDY_BIT = 7;
    localparam int BYTE_ORDER_BIT = 0;
    localparam int FAST_READ_BIT = 1;
    localparam int MAG_EN_BIT = 0;

    // Reset values
    localparam logic [7:0] CFG2_RST = 8'h00;
    localparam logic [7:0] CFG5_RST = 8'h00;
    localparam logic [11:0] VECTOR_MAGNITUDE_VALUE_RST = 12'h000;

    typedef enum logic [1:0] {
        AOD_CH_TEMP,
        AOD_CH_X,
        AOD_CH_Y,
        AOD_CH_Z
    } aod_chan_type;

    // One complete output data set
    typedef struct packed {
        logic [7:0] temp;
        logic [11:0] x;
        logic [11:0] y;
        logic [11:0] z;
    } aod_sample_type;

    // Serial bus pins driven by the host
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } aod_spi_in_type;
endpackage

// File: test/aod_output_regs_monitor.sv
`timescale 1ns/1ps
module aod_output_regs_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire aod_pkg::aod_spi_in_type spi_in,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    input wire logic sample_start,
    input wire logic conv_req,
    input wire aod_pkg::aod_chan_type conv_chan,
    input wire logic [11:0] conv_data,
    input wire logic conv_valid,
    input wire logic data_ready
);
    import aod_pkg::*;
    logic busy_r;
    logic dr_r;
    logic [1:0] chan_r;
    logic [11:0] gap_r;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // One set is busy from its start until the flag rises
    always_ff @(posedge ref_clk) begin
        if (rst) busy_r <= 1'b0;
        else if (sample_start) busy_r <= 1'b1;
        else if (data_ready && !dr_r) busy_r <= 1'b0;
    end
    always_ff @(posedge ref_clk) begin
        dr_r <= rst ? 1'b0 : data_ready;
    end
    // Last requested channel
    always_ff @(posedge ref_clk) begin
        if (rst) chan_r <= 2'h0;
        else if (conv_req) chan_r <= conv_chan;
    end
    // Cycles since the last result; saturates so it never wraps
    always_ff @(posedge ref_clk) begin
        if (rst) gap_r <= 12'h000;
        else if (conv_valid) gap_r <= 12'h001;
        else if (gap_r != 12'h000 && gap_r != 12'hFFF)
            gap_r <= gap_r + 12'h001;
    end

    a_reset_quiet: assert property ($fell(rst) |-> !data_ready && !conv_req
        && !spi_miso_oe) else $error("outputs not idle after reset");
    a_start_req: assert property (sample_start && !busy_r |=> conv_req
        && conv_chan == AOD_CH_TEMP) else $error("no temperature request");
    a_req_pulse: assert property (conv_req |=> !conv_req)
        else $error("request longer than one cycle");
    a_chan_order: assert property (conv_req && conv_chan != AOD_CH_TEMP
        |-> busy_r && conv_chan == 2'(chan_r + 2'h1))
        else $error("channel order broken");
    a_gap_time: assert property (conv_req && conv_chan != AOD_CH_TEMP
        |-> gap_r >= ACQ_GAP_CYC && gap_r <= ACQ_GAP_CYC + 3)
        else $error("conversion spacing wrong");
    a_ready_after_z: assert property (conv_valid && busy_r
        && conv_chan == AOD_CH_Z |-> ##[1:20] data_ready)
        else $error("flag late after last axis");
    a_ready_cause: assert property ($rose(data_ready) |-> busy_r
        && chan_r == 2'h3 && gap_r <= 12'h014) else $error("flag without set");
    a_start_once: assert property (conv_req && conv_chan == AOD_CH_TEMP
        |-> $past(sample_start) && !$past(busy_r))
        else $error("conversion set restarted while busy");
    a_ready_holds: assert property (data_ready && spi_in.cs_n
        |=> data_ready) else $error("flag cleared without a read");
endmodule

bind aod_output_regs aod_output_regs_monitor mon (.ref_clk, .rst, .spi_in,
    .spi_miso, .spi_miso_oe, .sample_start, .conv_req, .conv_chan,
    .conv_data, .conv_valid, .data_ready);

// File: test/aod_host_model.sv
`timescale 1ns/1ps
module aod_host_model (
    input wire logic ref_clk,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    output aod_pkg::aod_spi_in_type spi_in,
    output logic [7:0] rx_byte,
    output logic rx_stb
);
    import aod_pkg::*;
    logic last_r;
    logic miso_w;

    // A released line shows the inverse of its last bit, never a kind value
    always @(posedge ref_clk) begin
        if (spi_miso_oe) last_r <= spi_miso;
    end
    assign miso_w = spi_miso_oe ? spi_miso : ~last_r;

    initial begin
        spi_in = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
        rx_byte = 8'h00;
        rx_stb = 1'b0;
        last_r = 1'b0;
    end

    // Mode 0 frame; clock stands still outside frames. Pins change by
    // non-blocking assignment so the sync flops never race the host
    task xfer(input logic [7:0] cmd, input logic [7:0] wd, input int n);
        logic [7:0] b;
        spi_in.cs_n <= 1'b0;
        #100;
        for (int k = 0; k <= n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                spi_in.mosi <= k == 0 ? cmd[i] : wd[i];
                #100 spi_in.sclk <= 1'b1;
                b[i] = miso_w;
                #100 spi_in.sclk <= 1'b0;
            end
            if (k > 0 && cmd[7]) begin
                @(posedge ref_clk) rx_byte <= b;
                rx_stb <= 1'b1;
                @(posedge ref_clk) rx_stb <= 1'b0;
            end
        end
        #100 spi_in.cs_n <= 1'b1;
        #200;
    endtask
endmodule

// File: test/aod_output_regs_tb.sv
`timescale 1ns/1ps
module aod_output_regs_tb;
    import aod_pkg::*;
    logic ref_clk, rst, sample_start, conv_valid, spi_miso, spi_miso_oe;
    logic conv_req, data_ready, rx_stb;
    logic [11:0] conv_data, vm;
    logic [11:0] ax[4];
    logic [15:0] p;
    logic [7:0] rx_byte, e;
    logic [7:0] exp_q[$];
    aod_spi_in_type spi_in;
    aod_chan_type conv_chan;
    int n_mismatch, total_checks, i, k, m;

    aod_output_regs dut (.ref_clk, .rst, .spi_in, .spi_miso, .spi_miso_oe,
        .sample_start, .conv_req, .conv_chan, .conv_data, .conv_valid,
        .data_ready);
    aod_host_model host (.ref_clk, .spi_miso, .spi_miso_oe, .spi_in,
        .rx_byte, .rx_stb);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Converter stand-in answers one cycle after each request
    always @(posedge ref_clk) begin
        conv_valid <= conv_req;
        conv_data <= ax[conv_chan];
    end

    // Oldest expected byte against each byte the host receives
    always @(posedge ref_clk) begin
        if (rx_stb === 1'b1) begin
            e = exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX;
            total_checks++;
            if (rx_byte !== e) begin
                n_mismatch++;
                $display("mismatch at %0t: got %h expected %h", $time,
                    rx_byte, e);
            end
        end
    end

    // Register pair: low address first; a big-endian host recovers the
    // value by an arithmetic shift right of four
    function automatic logic [15:0] pack(input logic [11:0] v,
        input logic be, input logic sx);
        return be ? {v[11:4], v[3:0], 4'h0}
            : {v[7:0], sx ? {4{v[11]}} : 4'h0, v[11:8]};
    endfunction

    function automatic logic [11:0] mag(input logic [11:0] x, y, z);
        int s;
        int r;
        s = $signed(x) * $signed(x) + $signed(y) * $signed(y)
            + $signed(z) * $signed(z);
        r = 0;
        while ((r + 1) * (r + 1) <= s) r++;
        return 12'(r);
    endfunction

    task stop_test;
        if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #2_000_000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        sample_start = 1'b0;
        conv_data = 12'h000;
        ax = '{default: 12'h000};
        vm = 12'h000;
        void'($urandom(32'h5d43));
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        // A write to a read-only place must not stick
        host.xfer({1'b0, VECTOR_MAGNITUDE_VALUE_LO_ADDR}, 8'hFF, 1);
        repeat (9) exp_q.push_back(8'h00);
        host.xfer({1'b1, VECTOR_MAGNITUDE_VALUE_LO_ADDR}, 8'h00, 9);
        // Each pass: bit 0 byte order, bit 1 fast read
        for (m = 0; m < 4; m++) begin
            host.xfer({1'b0, CFG2_ADDR}, {6'h00, m[1], m[0]}, 1);
            if (m == 1) host.xfer({1'b0, CFG5_ADDR}, 8'h01, 1);
            for (i = 0; i < 4; i++) ax[i] = 12'($urandom);
            if (m == 0) ax[1] = 12'h800;
            @(posedge ref_clk) sample_start <= 1'b1;
            @(posedge ref_clk) sample_start <= 1'b0;
            // A second start while busy must be ignored
            repeat (50) @(posedge ref_clk);
            sample_start <= 1'b1;
            @(posedge ref_clk) sample_start <= 1'b0;
            k = 0;
            while (data_ready !== 1'b1 && k < 9000) begin
                @(posedge ref_clk);
                k++;
            end
            if (k == 9000) n_mismatch++;
            if (m != 0) vm = mag(ax[1], ax[2], ax[3]);
            exp_q.push_back(8'h80);
            exp_q.push_back(ax[0][7:0]);
            p = pack(vm, m[0], 1'b0);
            exp_q.push_back(p[15:8]);
            if (!m[1]) exp_q.push_back(p[7:0]);
            for (i = 1; i < 4; i++) begin
                p = pack(ax[i], m[0] | m[1], 1'b1);
                exp_q.push_back(p[15:8]);
                if (!m[1]) exp_q.push_back(p[7:0]);
            end
            host.xfer({1'b1, STATUS_ADDR}, 8'h00, m[1] ? 6 : 10);
            exp_q.push_back(8'h00);
            host.xfer({1'b1, STATUS_ADDR}, 8'h00, 1);
        end
        stop_test();
    end
endmodule
